/* tb_urs_shadow_ctl.sv */
// Directed bench for the shadow control block, driven through AXI4-Lite tasks.
// Assumes the far-side model supplies serial ticks and decodes the enable pins.
`timescale 1ns/10ps
`default_nettype none
module tb_urs_shadow_ctl
    import urs_pkg::*;
;
    localparam int RX_THR [4] = '{1, 4, 8, 14};
    localparam int TX_THR [4] = '{0, 2, 4, 8};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, lastResp;
    logic [31:0] s_axi_rdata, lastData;
    logic [LVL_W-1:0] rxLevel = '0, txLevel = '0;
    logic rxBusy = 1'b0, txProgEmptyMode = 1'b0, txReqIn = 1'b0, txSingleIn = 1'b0, rxSingleIn = 1'b0;
    logic rxDataAvail, txEmptyIrq, txPause, txGoAllowed, drive_gate_out, listen_gate_out;
    logic dma_tx_ask_n, dma_tx_single_n, dma_rx_ask_n, dma_rx_single_n;
    logic sclkTick, lineDriven, lineListened;
    logic drivePol = 1'b1, listenPol = 1'b1, exclMode = 1'b0, compMode = 1'b0;
    logic [3:0] dmaPins;
    int fails = 0;
    int n_checks = 0;
    int tickCnt = 0;
    int badDir = 0;
    assign dmaPins = {dma_tx_ask_n, dma_tx_single_n, dma_rx_ask_n, dma_rx_single_n};
    urs_shadow_ctl i_dut (
        .clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sclkTick, .rxLevel, .txLevel, .rxBusy, .txProgEmptyMode, .txReqIn, .txSingleIn, .rxSingleIn,
        .rxDataAvail, .txEmptyIrq, .txPause, .txGoAllowed, .dma_tx_ask_n, .dma_tx_single_n,
        .dma_rx_ask_n, .dma_rx_single_n, .drive_gate_out, .listen_gate_out
    );
    urs_xcvr_model #(.TICK_DIV(4)) i_line (
        .clk, .arst_n, .drive_gate_out, .listen_gate_out, .drivePol, .listenPol, .sclkTick,
        .lineDriven, .lineListened
    );
    always #20 clk = ~clk;
    always @(posedge clk) if (sclkTick) tickCnt <= tickCnt + 1;
    // Mode 1 forbids overlap; mode 2 demands strict complement
    always @(negedge clk) if ((exclMode && lineDriven && lineListened) || (compMode && lineDriven == lineListened)) badDir++;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                lastResp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                lastData = s_axi_rdata;
                lastResp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a);
        chk(what, lastData, exp);
    endtask
    // Lower bound only: the start mark is taken before the cause, never after it
    task automatic wait_line(input logic lsn, input int t0);
        int k;
        k = 0;
        while ((lsn ? lineListened : lineDriven) !== 1'b1 && k < 400) begin
            @(negedge clk);
            k++;
        end
        chk("line reached", 32'(k < 400), 32'h1);
        chk("turn ticks", 32'(tickCnt - t0 >= 3), 32'h1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        logic ackSeen;
        int t0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk("rx_trig rst", OFS_RX_TRIG, 32'h0);
        rd_chk("tx_empty rst", OFS_TX_EMPTY, 32'h0);
        rd_chk("pause rst", OFS_TX_PAUSE, 32'h0);
        rd_chk("dma ack rst", OFS_DMA_ACK, 32'h0);
        rd_chk("xcvr rst", OFS_XCVR, 32'h4);
        rd_chk("drive rst", OFS_DRIVE, 32'h0);
        axi_rd(8'h40);
        chk("unmapped resp", lastResp, RESP_SLVERR);
        axi_wr(8'h40, 32'h0);
        chk("unmapped wr resp", lastResp, RESP_SLVERR);
        axi_wr(OFS_DRIVE, 32'h1);
        settle(2);
        chk("pins multidrop off", {drive_gate_out, listen_gate_out}, 2'b00);
        $display("test reset values done");
        axi_wr(OFS_FIFO_CTL, 32'h09);
        for (int c = 0; c < 4; c++) begin
            axi_wr(OFS_RX_TRIG, 32'hFFFF_FFFC | c);
            rd_chk("rx_trig", OFS_RX_TRIG, c);
            rd_chk("fifo_ctl rx", OFS_FIFO_CTL, (c << 6) | 32'h09);
            @(posedge clk) rxLevel <= LVL_W'(RX_THR[c] - 1);
            settle(3);
            chk("rx below", {rxDataAvail, dma_rx_ask_n}, 2'b01);
            @(posedge clk) rxLevel <= LVL_W'(RX_THR[c]);
            settle(3);
            chk("rx at trigger", {rxDataAvail, dma_rx_ask_n}, 2'b10);
            @(posedge clk) rxLevel <= '0;
        end
        @(posedge clk) txProgEmptyMode <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            axi_wr(OFS_TX_EMPTY, 32'hFFFF_FFFC | c);
            rd_chk("tx_empty", OFS_TX_EMPTY, c);
            rd_chk("fifo_ctl tx", OFS_FIFO_CTL, (c << 4) | 32'hC9);
            @(posedge clk) txLevel <= LVL_W'(TX_THR[c] + 1);
            settle(3);
            chk("tx above", txEmptyIrq, 1'b0);
            @(posedge clk) txLevel <= LVL_W'(TX_THR[c]);
            settle(3);
            chk("tx at threshold", txEmptyIrq, 1'b1);
        end
        @(posedge clk) txLevel <= '0;
        $display("test triggers done");
        axi_wr(OFS_TX_PAUSE, 32'hFFFF_FFFF);
        rd_chk("pause", OFS_TX_PAUSE, 32'h1);
        settle(2);
        chk("pause on", {txPause, txGoAllowed}, 2'b10);
        axi_wr(OFS_FIFO_CTL, 32'h0);
        settle(2);
        chk("pause fifo off", {txPause, txGoAllowed}, 2'b01);
        axi_wr(OFS_TX_PAUSE, 32'h0);
        axi_wr(OFS_FIFO_CTL, 32'h09);
        $display("test pause done");
        @(posedge clk);
        txReqIn <= 1'b1;
        txSingleIn <= 1'b1;
        rxSingleIn <= 1'b1;
        rxLevel <= LVL_W'(2);
        settle(3);
        chk("dma asks", dmaPins, 4'h0);
        ackSeen = 1'b0;
        fork
            axi_wr(OFS_DMA_ACK, 32'h1);
            repeat (8) @(negedge clk) if (dmaPins === 4'hF) ackSeen = 1'b1;
        join
        chk("dma ack drop", ackSeen, 1'b1);
        settle(3);
        chk("dma ack clears", dmaPins, 4'h0);
        rd_chk("dma ack rd", OFS_DMA_ACK, 32'h0);
        $display("test dma done");
        axi_wr(OFS_XCVR, 32'hFFFF_FFE7);
        rd_chk("xcvr", OFS_XCVR, 32'h07);
        axi_wr(OFS_LISTEN, 32'h1);
        settle(2);
        chk("mode0 both", {drive_gate_out, listen_gate_out}, 2'b11);
        axi_wr(OFS_XCVR, 32'h01);
        settle(2);
        chk("active low", {drive_gate_out, listen_gate_out}, 2'b00);
        axi_wr(OFS_DRIVE, 32'h0);
        settle(2);
        chk("drive off low", {drive_gate_out, listen_gate_out}, 2'b10);
        axi_wr(OFS_TURN, 32'h0002_0002);
        rd_chk("turn", OFS_TURN, 32'h0002_0002);
        axi_wr(OFS_XCVR, 32'h0F);
        settle(3);
        chk("mode1 listen", {lineDriven, lineListened}, 2'b01);
        exclMode <= 1'b1;
        axi_wr(OFS_LISTEN, 32'h0);
        @(posedge clk) rxBusy <= 1'b1;
        settle(2);
        axi_wr(OFS_DRIVE, 32'h1);
        settle(4);
        chk("mode1 rx wait", {txGoAllowed, lineDriven}, 2'b00);
        t0 = tickCnt;
        @(posedge clk) rxBusy <= 1'b0;
        wait_line(1'b0, t0);
        t0 = tickCnt;
        axi_wr(OFS_DRIVE, 32'h0);
        axi_wr(OFS_LISTEN, 32'h1);
        wait_line(1'b1, t0);
        axi_wr(OFS_XCVR, 32'h17);
        settle(3);
        chk("mode2 listen", {lineDriven, lineListened}, 2'b01);
        compMode <= 1'b1;
        t0 = tickCnt;
        @(posedge clk) txLevel <= LVL_W'(3);
        wait_line(1'b0, t0);
        t0 = tickCnt;
        @(posedge clk) txLevel <= '0;
        wait_line(1'b1, t0);
        compMode <= 1'b0;
        exclMode <= 1'b0;
        chk("direction overlap", badDir, 0);
        axi_wr(OFS_XCVR, 32'h00);
        settle(2);
        chk("multidrop off", {drive_gate_out, listen_gate_out}, 2'b00);
        $display("test transceiver done");
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("ERROR watchdog expected finish seen hang");
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* urs_pkg.sv */
// Package for the multidrop shadow control block: register map, fields, modes, bus response codes.
// Assumes a 32-bit AXI4-Lite register bus and a single 25 MHz clock.
package urs_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam logic [7:0] OFS_RX_TRIG = 8'h9C;
    localparam logic [7:0] OFS_TX_EMPTY = 8'hA0;
    localparam logic [7:0] OFS_TX_PAUSE = 8'hA4;
    localparam logic [7:0] OFS_DMA_ACK = 8'hA8;
    localparam logic [7:0] OFS_XCVR = 8'hAC;
    localparam logic [7:0] OFS_DRIVE = 8'hB0;
    localparam logic [7:0] OFS_LISTEN = 8'hB4;
    localparam logic [7:0] OFS_TURN = 8'hBC;
    localparam logic [7:0] OFS_FIFO_CTL = 8'hE0;
    localparam logic [7:0] OFS_STATUS = 8'hE4;
    localparam int FCR_RXT_LSB = 6;
    localparam int FCR_TXT_LSB = 4;
    localparam int FCR_DMA_BIT = 3;
    localparam int FCR_EN_BIT = 0;
    localparam int XCVR_MODE_LSB = 3;
    localparam int XCVR_DPOL_BIT = 2;
    localparam int XCVR_LPOL_BIT = 1;
    localparam int XCVR_ON_BIT = 0;
    localparam int TURN_LSB = 0;
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_MANUAL = 2'h1;
    localparam logic [1:0] MODE_AUTO = 2'h2;
    localparam int FIFO_DEPTH = 16;
    localparam int LVL_W = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {URS_LISTEN, URS_TO_DRIVE, URS_DRIVE, URS_TO_LISTEN} urs_dir_t;
endpackage

/* urs_shadow_ctl.sv */
// Shadow FIFO trigger, transmit pause, DMA soft ack and multidrop transceiver control.
// Assumes FIFO levels, busy flags and DMA requests come from the parent port on clk;
// serial-clock ticks arrive as a same-domain one-cycle strobe.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module urs_shadow_ctl
    import urs_pkg::*;
#(
    parameter bit FIFO_PARAM = 1'b1,
    parameter bit SHADOW_PARAM = 1'b1,
    parameter bit TX_EMPTY_IRQ_PARAM = 1'b1,
    parameter bit DMA_HANDSHAKE_PARAM = 1'b1,
    parameter bit MULTIDROP_IFACE_PARAM = 1'b1,
    parameter bit DRIVE_POL_INIT = 1'b1,
    parameter bit LISTEN_POL_INIT = 1'b0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sclkTick,
    input wire logic [LVL_W-1:0] rxLevel,
    input wire logic [LVL_W-1:0] txLevel,
    input wire logic rxBusy,
    input wire logic txProgEmptyMode,
    input wire logic txReqIn,
    input wire logic txSingleIn,
    input wire logic rxSingleIn,
    output logic rxDataAvail,
    output logic txEmptyIrq,
    output logic txPause,
    output logic txGoAllowed,
    output logic dma_tx_ask_n,
    output logic dma_tx_single_n,
    output logic dma_rx_ask_n,
    output logic dma_rx_single_n,
    output logic drive_gate_out,
    output logic listen_gate_out
);
    localparam bit HAS_TRIG = FIFO_PARAM && SHADOW_PARAM;
    localparam bit HAS_TXT = HAS_TRIG && TX_EMPTY_IRQ_PARAM;

    typedef struct packed {
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [7:0] fifoCtl;
        logic pause;
        logic softAck;
        logic [4:0] xcvr;
        logic driveEn;
        logic listenEn;
        logic [31:0] turn;
        logic [15:0] turnCnt;
        urs_dir_t dir;
        logic rxBusyS1;
        logic rxBusyS2;
        logic rxAvail;
        logic txIrq;
        logic pauseOut;
        logic goOk;
        logic txAskN;
        logic txSingleN;
        logic rxAskN;
        logic rxSingleN;
        logic drivePin;
        logic listenPin;
    } urs_state_t;

    urs_state_t s_q;
    urs_state_t s_d;

    // Trigger level in FIFO entries for a two-bit receive code
    function automatic logic [LVL_W-1:0] rxThresh(input logic [1:0] code);
        unique case (code)
            2'h0: rxThresh = LVL_W'(1);
            2'h1: rxThresh = LVL_W'(FIFO_DEPTH / 4);
            2'h2: rxThresh = LVL_W'(FIFO_DEPTH / 2);
            2'h3: rxThresh = LVL_W'(FIFO_DEPTH - 2);
        endcase
    endfunction

    function automatic logic [LVL_W-1:0] txThresh(input logic [1:0] code);
        unique case (code)
            2'h0: txThresh = LVL_W'(0);
            2'h1: txThresh = LVL_W'(2);
            2'h2: txThresh = LVL_W'(FIFO_DEPTH / 4);
            2'h3: txThresh = LVL_W'(FIFO_DEPTH / 2);
        endcase
    endfunction

    logic fifoOn;
    logic mdOn;
    logic [1:0] mode;
    logic driveSt;
    logic listenSt;
    logic doWrite;
    logic [31:0] wMask;
    logic [31:0] nv;
    logic ackNow;

    always_comb begin
        s_d = s_q;
        fifoOn = FIFO_PARAM && s_q.fifoCtl[FCR_EN_BIT];
        mdOn = MULTIDROP_IFACE_PARAM && s_q.xcvr[XCVR_ON_BIT];
        mode = s_q.xcvr[XCVR_MODE_LSB +: 2];
        // AXI write: address and data taken in either order, response after both
        s_d.awHeld = s_q.awHeld || s_axi_awvalid;
        s_d.wHeld = s_q.wHeld || s_axi_wvalid;
        if (!s_q.awHeld && s_axi_awvalid) begin
            s_d.awAddr = s_axi_awaddr;
        end
        if (!s_q.wHeld && s_axi_wvalid) begin
            s_d.wData = s_axi_wdata;
            s_d.wStrb = s_axi_wstrb;
        end
        doWrite = s_q.awHeld && s_q.wHeld && !s_q.bValid;
        for (int i = 0; i < 4; i++) begin
            wMask[i*8 +: 8] = {8{s_q.wStrb[i]}};
        end
        nv = (s_q.wData & wMask);
        ackNow = 1'b0;
        s_d.softAck = 1'b0; // Self-clearing
        if (doWrite) begin
            s_d.awHeld = 1'b0;
            s_d.wHeld = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp = RESP_OKAY;
            unique case (s_q.awAddr)
                OFS_RX_TRIG: if (HAS_TRIG && s_q.wStrb[0]) s_d.fifoCtl[FCR_RXT_LSB +: 2] = nv[1:0];
                OFS_TX_EMPTY: if (HAS_TXT && s_q.wStrb[0]) s_d.fifoCtl[FCR_TXT_LSB +: 2] = nv[1:0];
                OFS_TX_PAUSE: if (FIFO_PARAM && s_q.wStrb[0]) s_d.pause = nv[0];
                OFS_DMA_ACK: if (DMA_HANDSHAKE_PARAM && nv[0]) ackNow = 1'b1;
                OFS_XCVR: if (MULTIDROP_IFACE_PARAM && s_q.wStrb[0]) s_d.xcvr = nv[4:0];
                OFS_DRIVE: if (MULTIDROP_IFACE_PARAM && s_q.wStrb[0]) s_d.driveEn = nv[0];
                OFS_LISTEN: if (MULTIDROP_IFACE_PARAM && s_q.wStrb[0]) s_d.listenEn = nv[0];
                OFS_TURN: if (MULTIDROP_IFACE_PARAM) s_d.turn = (s_q.turn & ~wMask) | nv;
                OFS_FIFO_CTL: if (FIFO_PARAM && s_q.wStrb[0]) s_d.fifoCtl = nv[7:0];
                OFS_STATUS: s_d.bResp = RESP_OKAY;
                default: s_d.bResp = RESP_SLVERR;
            endcase
            if (ackNow) begin
                s_d.softAck = 1'b1;
            end
        end
        if (s_q.bValid && s_axi_bready) begin
            s_d.bValid = 1'b0;
        end
        // AXI read: one-cycle arready, data the cycle after
        s_d.arReady = s_axi_arvalid && !s_q.arReady && !s_q.rValid;
        if (s_axi_arvalid && s_q.arReady) begin
            s_d.rValid = 1'b1;
            s_d.rResp = RESP_OKAY;
            s_d.rData = 32'h0; // Upper bits stay zero, except OFS_TURN, which returns all 32 bits
            unique case (s_axi_araddr)
                OFS_RX_TRIG: s_d.rData[1:0] = HAS_TRIG ? s_q.fifoCtl[FCR_RXT_LSB +: 2] : 2'h0;
                OFS_TX_EMPTY: s_d.rData[1:0] = HAS_TXT ? s_q.fifoCtl[FCR_TXT_LSB +: 2] : 2'h0;
                OFS_TX_PAUSE: s_d.rData[0] = s_q.pause;
                OFS_DMA_ACK: s_d.rData = 32'h0;
                OFS_XCVR: s_d.rData[4:0] = MULTIDROP_IFACE_PARAM ? s_q.xcvr : 5'h0;
                OFS_DRIVE: s_d.rData[0] = MULTIDROP_IFACE_PARAM && s_q.driveEn;
                OFS_LISTEN: s_d.rData[0] = MULTIDROP_IFACE_PARAM && s_q.listenEn;
                OFS_TURN: s_d.rData = MULTIDROP_IFACE_PARAM ? s_q.turn : 32'h0;
                OFS_FIFO_CTL: s_d.rData[7:0] = s_q.fifoCtl;
                OFS_STATUS: s_d.rData[3:0] = {s_q.dir == URS_DRIVE, s_q.rxBusyS2, s_q.rxAvail, s_q.txIrq};
                default: s_d.rResp = RESP_SLVERR;
            endcase
        end else if (s_q.rValid && s_axi_rready) begin
            s_d.rValid = 1'b0;
        end
        s_d.rxBusyS1 = rxBusy;
        s_d.rxBusyS2 = s_q.rxBusyS1;
        // Interrupt levels and DMA handshakes
        s_d.rxAvail = fifoOn ? (rxLevel >= rxThresh(s_q.fifoCtl[FCR_RXT_LSB +: 2])) : (rxLevel != '0);
        s_d.txIrq = (txProgEmptyMode && fifoOn)
            ? (txLevel <= txThresh(s_q.fifoCtl[FCR_TXT_LSB +: 2])) : (txLevel == '0);
        s_d.pauseOut = s_q.pause && fifoOn;
        // Ack drops all handshakes immediately and holds them for two cycles
        s_d.txAskN = !(txReqIn && !ackNow && !s_q.softAck);
        s_d.txSingleN = !(txSingleIn && !ackNow && !s_q.softAck);
        s_d.rxAskN = !((s_q.fifoCtl[FCR_DMA_BIT] && fifoOn
            ? s_d.rxAvail : rxLevel != '0) && !ackNow && !s_q.softAck);
        s_d.rxSingleN = !(rxSingleIn && !ackNow && !s_q.softAck);
        // Transceiver direction; mode 1 and 2 switch through turnaround
        if (sclkTick && s_q.turnCnt != 16'h0) begin
            s_d.turnCnt = s_q.turnCnt - 16'h1;
        end
        driveSt = 1'b0;
        listenSt = 1'b0;
        if (!mdOn) begin
            s_d.dir = URS_LISTEN; // Plain port, enables ignored
        end else if (mode == MODE_FULL) begin
            driveSt = s_q.driveEn;
            listenSt = s_q.listenEn;
            s_d.dir = URS_LISTEN;
        end else begin
            unique case (s_q.dir)
                URS_LISTEN: begin
                    listenSt = (mode == MODE_AUTO) || s_q.listenEn;
                    if (!s_q.rxBusyS2 && (mode == MODE_AUTO ? txLevel != '0 : s_q.driveEn)) begin
                        s_d.dir = URS_TO_DRIVE;
                        s_d.turnCnt = s_q.turn[31:16] + 16'h1;
                    end
                end
                URS_TO_DRIVE: if (s_q.turnCnt == 16'h0) s_d.dir = URS_DRIVE;
                URS_DRIVE: begin
                    driveSt = 1'b1;
                    if (mode == MODE_AUTO ? txLevel == '0 : !s_q.driveEn) begin
                        s_d.dir = URS_TO_LISTEN;
                        s_d.turnCnt = s_q.turn[TURN_LSB +: 16] + 16'h1;
                    end
                end
                URS_TO_LISTEN: begin
                    // Auto mode keeps driving through the turnaround so the pins never overlap or gap
                    driveSt = (mode == MODE_AUTO);
                    if (s_q.turnCnt == 16'h0) begin
                        s_d.dir = URS_LISTEN;
                    end
                end
            endcase
            if (mode == MODE_AUTO) begin
                listenSt = !driveSt; // Complementary in automatic mode
            end
        end
        s_d.goOk = !s_d.pauseOut && (!mdOn || mode == MODE_FULL || s_q.dir == URS_DRIVE);
        s_d.drivePin = mdOn ? (driveSt ~^ s_q.xcvr[XCVR_DPOL_BIT]) : 1'b0;
        s_d.listenPin = mdOn ? (listenSt ~^ s_q.xcvr[XCVR_LPOL_BIT]) : 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.xcvr <= {2'h0, DRIVE_POL_INIT, LISTEN_POL_INIT, 1'b0};
            s_q.rResp <= RESP_OKAY;
            s_q.dir <= URS_LISTEN;
            s_q.txAskN <= 1'b1;
            s_q.txSingleN <= 1'b1;
            s_q.rxAskN <= 1'b1;
            s_q.rxSingleN <= 1'b1;
            s_q.goOk <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = !s_q.awHeld;
    assign s_axi_wready = !s_q.wHeld;
    assign s_axi_bvalid = s_q.bValid;
    assign s_axi_bresp = s_q.bResp;
    assign s_axi_arready = s_q.arReady;
    assign s_axi_rvalid = s_q.rValid;
    assign s_axi_rdata = s_q.rData;
    assign s_axi_rresp = s_q.rResp;
    assign rxDataAvail = s_q.rxAvail;
    assign txEmptyIrq = s_q.txIrq;
    assign txPause = s_q.pauseOut;
    assign txGoAllowed = s_q.goOk;
    assign dma_tx_ask_n = s_q.txAskN;
    assign dma_tx_single_n = s_q.txSingleN;
    assign dma_rx_ask_n = s_q.rxAskN;
    assign dma_rx_single_n = s_q.rxSingleN;
    assign drive_gate_out = s_q.drivePin;
    assign listen_gate_out = s_q.listenPin;

    a_soft_ack_drop: assert property (@(posedge clk) disable iff (!arst_n)
        s_q.softAck |-> dma_tx_ask_n && dma_rx_ask_n && dma_tx_single_n && dma_rx_single_n)
        else $error("DMA handshake active after soft ack");
    a_ack_self_clear: assert property (@(posedge clk) disable iff (!arst_n)
        s_q.softAck |=> !s_q.softAck || $past(ackNow))
        else $error("Soft ack did not clear");
    a_auto_complement: assert property (@(posedge clk) disable iff (!arst_n)
        (mdOn && mode == MODE_AUTO) |=> (drive_gate_out ~^ $past(s_q.xcvr[XCVR_DPOL_BIT]))
        != (listen_gate_out ~^ $past(s_q.xcvr[XCVR_LPOL_BIT])))
        else $error("Drive and listen not complementary");
    a_plain_port: assert property (@(posedge clk) disable iff (!arst_n)
        !mdOn |=> !drive_gate_out && !listen_gate_out)
        else $error("Enable pin active with multidrop off");
    a_pause_gate: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.pause && !fifoOn) |=> !txPause)
        else $error("Pause active with FIFOs disabled");
    a_pause_stop: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.pause && fifoOn) |=> txPause && !txGoAllowed)
        else $error("Transmit start allowed while paused");
    a_rx_trigger: assert property (@(posedge clk) disable iff (!arst_n)
        (fifoOn && rxLevel >= rxThresh(s_q.fifoCtl[FCR_RXT_LSB +: 2])) |=> rxDataAvail)
        else $error("Receive trigger missed");
    a_rx_dma_ask: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.fifoCtl[FCR_DMA_BIT] && fifoOn && !ackNow && !s_q.softAck
        && rxLevel >= rxThresh(s_q.fifoCtl[FCR_RXT_LSB +: 2])) |=> !dma_rx_ask_n)
        else $error("Receive DMA request missed at trigger");
    a_turn_wait: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.dir == URS_TO_LISTEN && s_q.turnCnt != 16'h0) |=> s_q.dir != URS_LISTEN || !mdOn || mode == MODE_FULL)
        else $error("Turnaround cut short");
    a_drive_after_rx: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.dir == URS_LISTEN && s_q.rxBusyS2 && mdOn) |=> s_q.dir != URS_TO_DRIVE)
        else $error("Drive started during reception");
endmodule
`default_nettype wire

/* urs_xcvr_model.sv */
// Far-side model: line transceiver that decodes the enable pins, plus the serial tick source.
// Assumes the block's clk; the bench tells it the pin polarities it has programmed.
`timescale 1ns/10ps
`default_nettype none
module urs_xcvr_model #(
    parameter int TICK_DIV = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic drive_gate_out,
    input wire logic listen_gate_out,
    input wire logic drivePol,
    input wire logic listenPol,
    output logic sclkTick,
    output logic lineDriven,
    output logic lineListened
);
    logic [7:0] divCnt_q;
    // Tick runs free, so turnaround counts keep moving between frames
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            divCnt_q <= 8'h00;
        end else begin
            divCnt_q <= (divCnt_q == 8'(TICK_DIV - 1)) ? 8'h00 : divCnt_q + 8'h01;
        end
    end
    assign sclkTick = (divCnt_q == 8'(TICK_DIV - 1));
    // A pin counts as active only at the level its polarity bit selects
    assign lineDriven = (drive_gate_out == drivePol);
    assign lineListened = (listen_gate_out == listenPol);
endmodule
`default_nettype wire
